// ==== pkg/asf_map.svh ====
// constants of the addressable section framer
//
// Behaviour
// - Every section opens with table identifier 0x3F and the following bit is always zero.
// - The error-detection type bit set to one marks the trailing word as a checksum, zero as a CRC32.
// - The 12-bit section length counts the bytes from address byte 6 to the end, check word included.
// - Address byte 6 follows the length field and address byte 5 follows it.
// - Payload and address scrambling are two 2-bit controls where 00b means sent in the clear.
// - An LLC/SNAP flag of one means the datagram is LLC encapsulated.
// - The sender clears the LLC/SNAP flag only for IP datagrams carried without LLC.
// - The announced encapsulation value is 0x03 for LLC/SNAP and 0x04 for plain IP.
// - Section number and last section number are both 0x00 since one datagram fills one section.
// - After the section numbers come address byte 4 and then address byte 3.
// - Address byte 2 and then byte 1, the most significant, close the address before the payload.
// - With the flag at one the payload is an LLC structure, otherwise raw IP bytes.
// - Optional stuffing bytes may follow the datagram and are covered by the section length.
// - The section ends with a 32-bit CRC32 or checksum as the error-detection type selects.
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH

// ----------------------------------------
// fixed field values
// ----------------------------------------
`define ASF_TABLE_ID 8'h3F
`define ASF_ZERO_BIT 1'h0
`define ASF_RSV_ONES 2'h3
`define ASF_MARK_BIT 1'h1
`define ASF_SEC_NUM 8'h00
`define ASF_LAST_SEC 8'h00
`define ASF_SCR_CLEAR 2'h0
`define ASF_ENCAP_LLC 8'h03
`define ASF_ENCAP_IP 8'h04

// ----------------------------------------
// byte positions within the header
// ----------------------------------------
`define ASF_IDX_TID 4'h0
`define ASF_IDX_LENHI 4'h1
`define ASF_IDX_LENLO 4'h2
`define ASF_IDX_ADR6 4'h3
`define ASF_IDX_ADR5 4'h4
`define ASF_IDX_CTRL 4'h5
`define ASF_IDX_SNUM 4'h6
`define ASF_IDX_LSNUM 4'h7
`define ASF_IDX_ADR4 4'h8
`define ASF_IDX_ADR3 4'h9
`define ASF_IDX_ADR2 4'hA
`define ASF_IDX_ADR1 4'hB

// ----------------------------------------
// lengths
// ----------------------------------------
`define ASF_HDR_LAST 12'h00B
`define ASF_CHK_LAST 12'h003
`define ASF_LEN_OVERHEAD 12'h00D
`define ASF_MAX_SECLEN 4093

// ----------------------------------------
// reset values
// ----------------------------------------
`define ASF_RST_BYTE 8'h00
`define ASF_RST_ENCAP 8'h04

`endif

// ==== pkg/asf_pkg.sv ====
// types of the addressable section framer
package asf_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR = 4'h2,
        ST_PLD = 4'h4,
        ST_CHK = 4'h8
    } asf_state_t;

    typedef struct packed {
        logic [47:0] mac;
        logic [11:0] payLen;
        logic [31:0] checkWord;
        logic [1:0] payScr;
        logic [1:0] addrScr;
        logic errType;
        logic llc;
        logic isIp;
    } asf_req_t;
endpackage : asf_pkg

// ==== pkg/asf_hdr_if.sv ====
// header fields passed from the framer to its header byte generator
`timescale 1ns/1ps
interface asf_hdr_if;
    logic [3:0] idx;
    asf_pkg::asf_req_t req;
    logic [11:0] secLen;
    logic [7:0] hdrByte;

    modport ctl (output idx, output req, output secLen, input hdrByte);
    modport gen (input idx, input req, input secLen, output hdrByte);
endinterface : asf_hdr_if

// ==== verilog/asf_hdr_gen.sv ====
// header byte generator of the addressable section framer
`timescale 1ns/1ps
`include "asf_map.svh"
module asf_hdr_gen (
    // header fields and byte select
    asf_hdr_if.gen hdr
);
    function automatic logic [7:0] hdrByteOf(input logic [3:0] idx,
                                             input asf_pkg::asf_req_t r,
                                             input logic [11:0] len);
        logic [7:0] b;
        b = `ASF_RST_BYTE;
        case (idx)
            `ASF_IDX_TID: b = `ASF_TABLE_ID;
            `ASF_IDX_LENHI: b = {`ASF_ZERO_BIT, r.errType, `ASF_RSV_ONES, len[11:8]};
            `ASF_IDX_LENLO: b = len[7:0];
            `ASF_IDX_ADR6: b = r.mac[7:0];
            `ASF_IDX_ADR5: b = r.mac[15:8];
            `ASF_IDX_CTRL: b = {`ASF_RSV_ONES, r.payScr, r.addrScr, r.llc, `ASF_MARK_BIT};
            `ASF_IDX_SNUM: b = `ASF_SEC_NUM;
            `ASF_IDX_LSNUM: b = `ASF_LAST_SEC;
            `ASF_IDX_ADR4: b = r.mac[23:16];
            `ASF_IDX_ADR3: b = r.mac[31:24];
            `ASF_IDX_ADR2: b = r.mac[39:32];
            `ASF_IDX_ADR1: b = r.mac[47:40];
            default: b = `ASF_RST_BYTE;
        endcase
        return b;
    endfunction : hdrByteOf

    always_comb begin
        hdr.hdrByte = hdrByteOf(hdr.idx, hdr.req, hdr.secLen);
    end
endmodule : asf_hdr_gen

// ==== verilog/asf_framer_host.sv ====
// section framer: wraps one datagram into one addressable section byte stream
`timescale 1ns/1ps
`include "asf_map.svh"
module asf_framer_host #(
    parameter int MAX_SECLEN = `ASF_MAX_SECLEN
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // datagram request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [47:0] reqMac,
    input wire logic [11:0] reqPayLen,
    input wire logic [31:0] reqCheckWord,
    input wire logic [1:0] reqPayScr,
    input wire logic [1:0] reqAddrScr,
    input wire logic reqErrType,
    input wire logic reqLlc,
    input wire logic reqIsIp,
    output logic reqErr,
    output logic [7:0] protoEncap,
    // payload bytes, datagram plus any stuffing
    input wire logic pldValid,
    output logic pldReady,
    input wire logic [7:0] pldData,
    // section bytes toward the multiplexer
    output logic secValid,
    input wire logic secReady,
    output logic [7:0] secData,
    output logic secStart,
    output logic secEnd
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (MAX_SECLEN > 4093 || MAX_SECLEN < 13) begin : g_bad_len
        $error("MAX_SECLEN out of range");
    end

    localparam logic [11:0] MAX_PAY = 12'(MAX_SECLEN - 13);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] chkByteOf(input logic [31:0] w, input logic [1:0] n);
        logic [7:0] b;
        b = `ASF_RST_BYTE;
        case (n)
            2'h0: b = w[31:24];
            2'h1: b = w[23:16];
            2'h2: b = w[15:8];
            2'h3: b = w[7:0];
            default: b = `ASF_RST_BYTE;
        endcase
        return b;
    endfunction : chkByteOf

    function automatic logic [7:0] encapOf(input logic llc);
        return llc ? `ASF_ENCAP_LLC : `ASF_ENCAP_IP;
    endfunction : encapOf

    // ----------------------------------------
    // state
    // ----------------------------------------
    asf_pkg::asf_state_t state_q, state_d;
    asf_pkg::asf_req_t req_q, req_d;
    logic [11:0] secLen_q, secLen_d;
    logic [11:0] cnt_q, cnt_d;
    logic reqReady_q, reqReady_d;
    logic reqErr_q, reqErr_d;
    logic [7:0] encap_q, encap_d;
    logic pldReady_q, pldReady_d;
    logic secValid_q, secValid_d;
    logic [7:0] secData_q, secData_d;
    logic secStart_q, secStart_d;
    logic secEnd_q, secEnd_d;
    logic slotFree;
    logic load;
    logic [7:0] loadByte;
    logic loadStart;
    logic loadEnd;
    asf_pkg::asf_req_t inReq;

    asf_hdr_if hdr ();

    assign hdr.idx = cnt_q[3:0];
    assign hdr.req = req_q;
    assign hdr.secLen = secLen_q;

    asf_hdr_gen u_hdr (
        .hdr(hdr)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        secLen_d = secLen_q;
        cnt_d = cnt_q;
        reqErr_d = 1'b0;
        encap_d = encap_q;
        load = 1'b0;
        loadByte = `ASF_RST_BYTE;
        loadStart = 1'b0;
        loadEnd = 1'b0;
        slotFree = !secValid_q || secReady;
        inReq.mac = reqMac;
        inReq.payLen = reqPayLen;
        inReq.checkWord = reqCheckWord;
        inReq.payScr = reqPayScr;
        inReq.addrScr = reqAddrScr;
        inReq.errType = reqErrType;
        // a non-IP datagram always goes out LLC encapsulated
        inReq.llc = reqLlc || !reqIsIp;
        inReq.isIp = reqIsIp;
        case (state_q)
            asf_pkg::ST_IDLE: begin
                if (reqValid && reqReady_q) begin
                    if (reqPayLen > MAX_PAY) begin
                        // too long for one section: refuse, never split
                        reqErr_d = 1'b1;
                    end else begin
                        req_d = inReq;
                        secLen_d = reqPayLen + `ASF_LEN_OVERHEAD;
                        encap_d = encapOf(inReq.llc);
                        cnt_d = 12'h000;
                        state_d = asf_pkg::ST_HDR;
                    end
                end
            end
            asf_pkg::ST_HDR: begin
                if (slotFree) begin
                    load = 1'b1;
                    loadByte = hdr.hdrByte;
                    loadStart = (cnt_q == 12'h000);
                    if (cnt_q == `ASF_HDR_LAST) begin
                        if (req_q.payLen == 12'h000) begin
                            cnt_d = 12'h000;
                            state_d = asf_pkg::ST_CHK;
                        end else begin
                            cnt_d = req_q.payLen;
                            state_d = asf_pkg::ST_PLD;
                        end
                    end else begin
                        cnt_d = cnt_q + 12'h001;
                    end
                end
            end
            asf_pkg::ST_PLD: begin
                if (pldValid && pldReady_q) begin
                    load = 1'b1;
                    loadByte = pldData;
                    if (cnt_q == 12'h001) begin
                        cnt_d = 12'h000;
                        state_d = asf_pkg::ST_CHK;
                    end else begin
                        cnt_d = cnt_q - 12'h001;
                    end
                end
            end
            asf_pkg::ST_CHK: begin
                if (slotFree) begin
                    load = 1'b1;
                    loadByte = chkByteOf(req_q.checkWord, cnt_q[1:0]);
                    loadEnd = (cnt_q == `ASF_CHK_LAST);
                    if (cnt_q == `ASF_CHK_LAST) begin
                        state_d = asf_pkg::ST_IDLE;
                    end else begin
                        cnt_d = cnt_q + 12'h001;
                    end
                end
            end
            default: begin
                state_d = asf_pkg::ST_IDLE;
            end
        endcase
        secValid_d = load || (secValid_q && !secReady);
        secData_d = load ? loadByte : secData_q;
        secStart_d = load ? loadStart : secStart_q;
        secEnd_d = load ? loadEnd : secEnd_q;
        // registered ready: payload moves only into an empty slot, so a
        // payload byte takes two cycles; traded for flop-driven outputs
        pldReady_d = (state_d == asf_pkg::ST_PLD) && !secValid_d;
        // held low until the last check byte has left, so req_q stays put for the checks
        reqReady_d = (state_d == asf_pkg::ST_IDLE) && !secValid_d && !(reqValid && reqReady_q);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= asf_pkg::ST_IDLE;
            req_q <= '0;
            secLen_q <= 12'h000;
            cnt_q <= 12'h000;
            reqReady_q <= 1'b0;
            reqErr_q <= 1'b0;
            encap_q <= `ASF_RST_ENCAP;
            pldReady_q <= 1'b0;
            secValid_q <= 1'b0;
            secData_q <= `ASF_RST_BYTE;
            secStart_q <= 1'b0;
            secEnd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            secLen_q <= secLen_d;
            cnt_q <= cnt_d;
            reqReady_q <= reqReady_d;
            reqErr_q <= reqErr_d;
            encap_q <= encap_d;
            pldReady_q <= pldReady_d;
            secValid_q <= secValid_d;
            secData_q <= secData_d;
            secStart_q <= secStart_d;
            secEnd_q <= secEnd_d;
        end
    end

    assign reqReady = reqReady_q;
    assign reqErr = reqErr_q;
    assign protoEncap = encap_q;
    assign pldReady = pldReady_q;
    assign secValid = secValid_q;
    assign secData = secData_q;
    assign secStart = secStart_q;
    assign secEnd = secEnd_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [11:0] outIdx_q;

    // position of the byte now on the output within its section
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            outIdx_q <= 12'h000;
        end else if (secValid_q && secReady) begin
            outIdx_q <= secEnd_q ? 12'h000 : outIdx_q + 12'h001;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    table_id_a: assert property (secValid_q && outIdx_q == 12'h000 |->
        secStart_q && secData_q == `ASF_TABLE_ID)
        else $error("section does not open with the table identifier");

    len_byte_a: assert property (secValid_q && outIdx_q == 12'h001 |->
        secData_q[7] == 1'b0 && secData_q[6] == req_q.errType && secData_q[5:4] == 2'h3)
        else $error("length byte fixed bits or error type wrong");

    sec_len_a: assert property (secValid_q && secEnd_q |->
        outIdx_q == secLen_q + 12'h002)
        else $error("section length does not match bytes sent");

    addr_six_a: assert property (secValid_q && outIdx_q == 12'h003 |->
        secData_q == req_q.mac[7:0])
        else $error("address byte 6 misplaced");

    addr_low_a: assert property (secValid_q && outIdx_q == 12'h004 |->
        secData_q == req_q.mac[15:8])
        else $error("address byte 5 does not follow byte 6");

    ctrl_byte_a: assert property (secValid_q && outIdx_q == 12'h005 |->
        secData_q[7:6] == 2'h3 && secData_q[5:4] == req_q.payScr
        && secData_q[3:2] == req_q.addrScr && secData_q[0] == 1'b1)
        else $error("control byte malformed");

    llc_flag_a: assert property (secValid_q && outIdx_q == 12'h005 |->
        secData_q[1] == req_q.llc && (req_q.isIp || req_q.llc))
        else $error("LLC flag wrong or cleared for non-IP");

    encap_a: assert property (state_q == asf_pkg::ST_HDR |->
        protoEncap == (req_q.llc ? 8'h03 : 8'h04))
        else $error("announced encapsulation disagrees with flag");

    sec_num_a: assert property (secValid_q && (outIdx_q == 12'h006 || outIdx_q == 12'h007) |->
        secData_q == 8'h00)
        else $error("section numbering not zero");

    addr_mid_a: assert property (secValid_q && outIdx_q == 12'h009 |->
        secData_q == req_q.mac[31:24])
        else $error("address byte 3 misplaced");

    addr_top_a: assert property (secValid_q && outIdx_q == 12'h00B |->
        secData_q == req_q.mac[47:40])
        else $error("address byte 1 misplaced");

    check_tail_a: assert property (secValid_q && secEnd_q |->
        secData_q == req_q.checkWord[7:0])
        else $error("check word not last");

    hold_a: assert property (secValid_q && !secReady |=>
        secValid_q && $stable(secData_q) && $stable(secEnd_q))
        else $error("section byte changed while stalled");

    too_long_a: assert property (reqValid && reqReady_q && reqPayLen > MAX_PAY |=>
        reqErr_q && state_q == asf_pkg::ST_IDLE)
        else $error("oversized datagram not refused");
endmodule : asf_framer_host

// ==== bench/asf_mux_model.sv ====
// far-side section sink that paces and collects the framer output
`timescale 1ns/1ps
module asf_mux_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // section byte stream
    input wire logic secValid,
    output logic secReady,
    input wire logic [7:0] secData,
    input wire logic secStart,
    input wire logic secEnd,
    // pacing and progress
    input wire logic slowMode,
    output int doneCnt
);
    // ----------------------------------------
    // capture
    // ----------------------------------------
    logic [9:0] gotQ[$];
    int need;

    initial begin
        secReady = 1'b0;
        doneCnt = 0;
        need = 0;
    end

    // ready changes just after the edge, so a held byte is never lost
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            secReady <= 1'b0;
        end else begin
            if (secValid === 1'b1 && secReady === 1'b1) begin
                gotQ.push_back({secStart, secEnd, secData});
                // end of section found from the length only: zero, error-type and reserved bits masked, stuffing counted
                if (gotQ.size() == 3) need = 3 + {gotQ[1][3:0], gotQ[2][7:0]};
                if (gotQ.size() == need) doneCnt <= doneCnt + 1;
            end
            secReady <= #1 slowMode ? 1'($urandom_range(0, 1)) : 1'b1;
        end
    end
endmodule : asf_mux_model

// ==== bench/asf_framer_host_tb.sv ====
// self-checking bench of the section framer with a paced sink
`timescale 1ns/1ps
`define CHK(NAME, EXP, GOT) begin n_checks++; if ((EXP) !== (GOT)) begin n_fail++; \
    $display("[FAIL] %s expected %0h seen %0h", NAME, EXP, GOT); end end
module asf_framer_host_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reqValid = 1'b0, reqReady, reqErr;
    logic [47:0] reqMac = '0;
    logic [11:0] reqPayLen = '0;
    logic [31:0] reqCheckWord = '0;
    logic [1:0] reqPayScr = '0, reqAddrScr = '0;
    logic reqErrType = 1'b0, reqLlc = 1'b0, reqIsIp = 1'b0;
    logic [7:0] protoEncap, pldData = '0, secData;
    logic pldValid = 1'b0, pldReady, secValid, secReady, secStart, secEnd;
    logic slowMode = 1'b0;
    int doneCnt, n_fail = 0, n_checks = 0;
    logic [7:0] pq[$];

    always #2.5 core_clk = ~core_clk;

    asf_framer_host dut (.core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid),
        .reqReady(reqReady), .reqMac(reqMac), .reqPayLen(reqPayLen),
        .reqCheckWord(reqCheckWord), .reqPayScr(reqPayScr), .reqAddrScr(reqAddrScr),
        .reqErrType(reqErrType), .reqLlc(reqLlc), .reqIsIp(reqIsIp), .reqErr(reqErr),
        .protoEncap(protoEncap), .pldValid(pldValid), .pldReady(pldReady),
        .pldData(pldData), .secValid(secValid), .secReady(secReady), .secData(secData),
        .secStart(secStart), .secEnd(secEnd));

    asf_mux_model mux (.core_clk(core_clk), .rst_b(rst_b), .secValid(secValid),
        .secReady(secReady), .secData(secData), .secStart(secStart), .secEnd(secEnd),
        .slowMode(slowMode), .doneCnt(doneCnt));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic close_out();
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out

    task automatic give_up(input string what);
        n_fail++;
        $display("[FAIL] %s expected handshake seen none", what);
        close_out();
    endtask : give_up

    function automatic logic [7:0] exp_byte(input int i);
        logic [11:0] len;
        logic flag;
        int k;
        len = reqPayLen + 12'h00D;
        flag = reqLlc | ~reqIsIp;
        k = i - 12 - int'(reqPayLen);
        if (i >= 12 && k < 0) return pq[i - 12];
        if (k >= 0) return reqCheckWord[31 - 8 * k -: 8];
        case (i)
            0: return 8'h3F;
            1: return {1'b0, reqErrType, 2'h3, len[11:8]};
            2: return len[7:0];
            3: return reqMac[7:0];
            4: return reqMac[15:8];
            5: return {2'h3, reqPayScr, reqAddrScr, flag, 1'b1};
            6, 7: return 8'h00;
            8: return reqMac[23:16];
            9: return reqMac[31:24];
            10: return reqMac[39:32];
            default: return reqMac[47:40];
        endcase
    endfunction : exp_byte

    // request held from just after an edge until reqReady is seen high at an edge
    task automatic drive_req();
        int t;
        t = 0;
        reqValid = 1'b1;
        do begin
            @(posedge core_clk);
            t++;
        end while (reqReady !== 1'b1 && t < 50);
        if (reqReady !== 1'b1) give_up("reqReady");
        #1 reqValid = 1'b0;
    endtask : drive_req

    task automatic feed_payload();
        int k, t;
        for (k = 0; k < int'(reqPayLen); k++) begin
            if ($urandom_range(0, 3) == 0) begin
                pldValid = 1'b0;
                repeat ($urandom_range(1, 3)) @(posedge core_clk);
                #1;
            end
            pldValid = 1'b1;
            pldData = pq[k];
            t = 0;
            do begin
                @(posedge core_clk);
                t++;
            end while (pldReady !== 1'b1 && t < 300);
            if (pldReady !== 1'b1) give_up("pldReady");
            #1;
        end
        pldValid = 1'b0;
    endtask : feed_payload

    // one datagram with the fields already on the request inputs
    task automatic run_section(input logic [11:0] len, input logic slow);
        int t, base, i;
        base = doneCnt;
        mux.gotQ.delete();
        pq.delete();
        slowMode = slow;
        reqPayLen = len;
        for (i = 0; i < int'(len); i++) pq.push_back(8'($urandom_range(0, 255)));
        drive_req();
        fork
            feed_payload();
            begin
                t = 0;
                while (doneCnt == base && t < 20000) begin
                    @(posedge core_clk);
                    t++;
                end
                if (doneCnt == base) give_up("doneCnt");
            end
        join
        #1;
        `CHK("protoEncap", (reqLlc | ~reqIsIp) ? 8'h03 : 8'h04, protoEncap)
        `CHK("sectionSize", 16 + int'(len), mux.gotQ.size())
        for (i = 0; i < mux.gotQ.size() && i < 16 + int'(len); i++) begin
            `CHK("secData", exp_byte(i), mux.gotQ[i][7:0])
            `CHK("secStart", i == 0, mux.gotQ[i][9])
            `CHK("secEnd", i == 15 + int'(len), mux.gotQ[i][8])
        end
    endtask : run_section

    task automatic rand_fields();
        reqMac = {16'($urandom()), $urandom()};
        reqCheckWord = $urandom();
        reqPayScr = 2'($urandom_range(0, 3));
        reqAddrScr = 2'($urandom_range(0, 3));
        reqErrType = 1'($urandom_range(0, 1));
        reqLlc = 1'($urandom_range(0, 1));
        reqIsIp = 1'($urandom_range(0, 1));
    endtask : rand_fields

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int k;
        logic [11:0] lens[8];
        lens = '{12'h000, 12'h001, 12'h002, 12'h005, 12'h011, 12'h003, 12'h008, 12'h028};
        void'($urandom(52333));
        repeat (6) @(posedge core_clk);
        #1;
        `CHK("protoEncap", 8'h04, protoEncap)
        `CHK("secValid", 1'b0, secValid)
        `CHK("reqReady", 1'b0, reqReady)
        rst_b = 1'b1;
        // every scrambling code, both check types, all flag and protocol combinations
        for (k = 0; k < 8; k++) begin
            rand_fields();
            reqErrType = k[0];
            reqPayScr = k[1:0];
            reqAddrScr = ~k[1:0];
            {reqLlc, reqIsIp} = k[2:1];
            run_section(lens[k], k[2] ^ k[0]);
        end
        // largest section that still fits, then one byte over it
        rand_fields();
        run_section(12'hFF0, 1'b0);
        reqPayLen = 12'hFF1;
        mux.gotQ.delete();
        drive_req();
        `CHK("reqErr", 1'b1, reqErr)
        @(posedge core_clk);
        #1;
        `CHK("reqErr", 1'b0, reqErr)
        repeat (10) @(posedge core_clk);
        #1;
        `CHK("refusedSize", 0, mux.gotQ.size())
        for (k = 0; k < 6; k++) begin
            rand_fields();
            run_section(12'($urandom_range(0, 60)), 1'($urandom_range(0, 1)));
        end
        close_out();
    end
endmodule : asf_framer_host_tb
